// file: hw/mftcc_pkg.sv
// Constants for the multifunction timer with capture and compare.
// Assumes one 20 MHz clock and a plain word-addressed register port.
//
// Behaviour
// RULE1 - Counter advances on a prescaler tick, divide by 1 up to 128.
// RULE2 - Counter equal to compare-clear value sets the compare-clear request.
// RULE3 - Counter seen at zero sets the zero-detection request.
// RULE4 - Buffered and stopped: buffer write reaches compare-clear at once.
// RULE5 - Buffered and running: buffer moves to compare-clear only at zero.
// RULE6 - Counter cleared by reset, software clear, and up-count compare-clear match.
// RULE7 - Counter counts up only, or up then down.
// RULE8 - Compare channels evaluate on the prescaler tick.
// RULE9 - Six compare channels each set a flag and toggle a pin on match.
// RULE10 - Two compare channels may jointly toggle one output.
// RULE11 - Software presets every compare output level.
// RULE12 - Capture edge latches counter into channel register and sets request.
// RULE13 - Capture edge selectable rise, fall or both; edge direction recorded.
// RULE14 - Capture sampling happens on the counter tick.
// RULE15 - Four capture channels are independent.
// RULE16 - Dead time from a 16-bit timer keeps upper and lower arms apart.
// RULE17 - Dead time also applies in two-channel mode.
// RULE18 - Realtime compare match produces a pulse generator gate.
// RULE19 - Match starts a 16-bit timer; gate holds until the timer stops.
// RULE20 - Emergency stop input forces waveform outputs off.
// RULE21 - Emergency stop or timer underflow raises the generator request.
// RULE22 - Outputs pair 0/1, 2/3, 4/5; even upper, odd lower.
// RULE23 - Zero detection edge drives the converter start trigger.
// RULE24 - Compare-clear and zero-detection requests are separate outputs.
// RULE25 - Upper and lower of a pair are never active together.
package mftcc_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 5;
   localparam int N_OC = 6;
   localparam int N_IC = 4;
   localparam int N_PAIR = 3;
   localparam int PRESC_W = 7;

   // Register word addresses
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_STAT = 5'h01;
   localparam logic [4:0] ADDR_CCLR = 5'h02;
   localparam logic [4:0] ADDR_COUNT = 5'h03;
   localparam logic [4:0] ADDR_OCR0 = 5'h04;
   localparam logic [4:0] ADDR_OC_CTRL = 5'h0A;
   localparam logic [4:0] ADDR_OC_FLAG = 5'h0B;
   localparam logic [4:0] ADDR_ICR0 = 5'h0C;
   localparam logic [4:0] ADDR_IC_CTRL = 5'h10;
   localparam logic [4:0] ADDR_IC_FLAG = 5'h11;
   localparam logic [4:0] ADDR_WG_CTRL = 5'h12;
   localparam logic [4:0] ADDR_DEAD = 5'h13;
   localparam logic [4:0] ADDR_GATE = 5'h14;

   // Control register fields
   localparam int CTRL_STOP = 0;
   localparam int CTRL_UPDOWN = 1;
   localparam int CTRL_SCLR = 2;
   localparam int CTRL_BUFEN = 3;
   localparam int CTRL_CLK_LSB = 4;
   localparam logic [15:0] CTRL_RESET = 16'h0001;

   // Status register fields
   localparam int STAT_CCLR = 0;
   localparam int STAT_ZERO = 1;
   localparam int STAT_ESTOP = 2;
   localparam int STAT_UFLOW = 3;

   // Compare control fields
   localparam int OC_LEVEL_LSB = 0;
   localparam int OC_PAIR_LSB = 6;

   // Capture status field
   localparam int IC_RISE_LSB = 4;

   // Waveform control fields
   localparam int WG_DT_EN = 0;
   localparam int WG_TWO_CH = 1;
   localparam int WG_GATE_EN = 2;

   localparam logic [15:0] CCLR_RESET = 16'hFFFF;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [15:0] ONE16 = 16'h0001;

   typedef enum logic [1:0] {
      MFTCC_EDGE_NONE,
      MFTCC_EDGE_RISE,
      MFTCC_EDGE_FALL,
      MFTCC_EDGE_BOTH
   } mftcc_edge_t;
endpackage : mftcc_pkg

// file: hw/mftcc_top.sv
// Multifunction timer: free-running counter, six compares, four captures,
// waveform generator with dead time, gate timer and emergency stop.
// Assumes a synchronous word register port; pins arrive asynchronously.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mftcc_top (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [4:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic [3:0] i_capture_pin,
   input wire logic i_emergency_stop_input,
   output logic o_realtime_out_u_upper,
   output logic o_realtime_out_x_lower,
   output logic o_realtime_out_v_upper,
   output logic o_realtime_out_y_lower,
   output logic o_realtime_out_w_upper,
   output logic o_realtime_out_z_lower,
   output logic [5:0] o_compare_out,
   output logic o_pulse_generator_gate,
   output logic o_adc_trigger,
   output logic o_irq_compare_clear,
   output logic o_irq_zero,
   output logic [5:0] o_irq_compare,
   output logic [3:0] o_irq_capture,
   output logic o_irq_wavegen
);
   logic [15:0] ctrl_q;
   logic [15:0] cnt_q;
   logic dir_up_q;
   logic [6:0] presc_q;
   logic [15:0] cclr_q;
   logic [15:0] cclr_buf_q;
   logic [3:0] stat_q;
   logic [15:0] ocr_q [0:5];
   logic [5:0] oc_out_q;
   logic [2:0] oc_pair_q;
   logic [5:0] oc_flag_q;
   logic [15:0] icr_q [0:3];
   logic [7:0] ic_sel_q;
   logic [3:0] ic_flag_q;
   logic [3:0] ic_rise_q;
   logic [3:0] cap_s1_q;
   logic [3:0] cap_s2_q;
   logic [3:0] cap_prev_q;
   logic es_s1_q;
   logic es_s2_q;
   logic es_prev_q;
   logic [2:0] wg_ctrl_q;
   logic [15:0] dead_q;
   logic [15:0] gate_rel_q;
   logic [15:0] gate_cnt_q;
   logic [5:0] rto_q;
   logic gate_q;
   logic adc_q;
   logic [15:0] rdata_q;

   logic tick;
   logic [6:0] presc_mask;
   logic running;
   logic zero_ev;
   logic cclr_ev;
   logic [5:0] match;
   logic [5:0] toggle;
   logic [3:0] cap_ev;
   logic es_ev;
   logic gate_uflow;
   logic [5:0] rto_d;
   logic wr_ctrl;
   logic wr_cclr;

   assign running = ~ctrl_q[mftcc_pkg::CTRL_STOP];
   assign presc_mask = 7'((8'h01 << ctrl_q[mftcc_pkg::CTRL_CLK_LSB +: 3]) - 8'h01);
   assign tick = running && ((presc_q & presc_mask) == presc_mask); // RULE1
   assign zero_ev = tick && (cnt_q == mftcc_pkg::ZERO16); // RULE3
   assign cclr_ev = tick && (cnt_q == cclr_q); // RULE2
   assign wr_ctrl = i_wr && (i_addr == mftcc_pkg::ADDR_CTRL);
   assign wr_cclr = i_wr && (i_addr == mftcc_pkg::ADDR_CCLR);
   assign es_ev = es_s2_q && !es_prev_q;
   assign gate_uflow = (gate_cnt_q == mftcc_pkg::ONE16);

   // Control register; software clear bit is self-clearing
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_q <= mftcc_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= i_wdata & ~(16'h0001 << mftcc_pkg::CTRL_SCLR);
      end
   end

   // Prescaler
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         presc_q <= 7'h00;
      end else if (!running) begin
         presc_q <= 7'h00;
      end else begin
         presc_q <= presc_q + 7'h01; // RULE1
      end
   end

   // Free-running counter
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= mftcc_pkg::ZERO16; // RULE6
         dir_up_q <= 1'b1;
      end else if (wr_ctrl && i_wdata[mftcc_pkg::CTRL_SCLR]) begin
         cnt_q <= mftcc_pkg::ZERO16; // RULE6
         dir_up_q <= 1'b1;
      end else if (tick) begin
         if (!ctrl_q[mftcc_pkg::CTRL_UPDOWN]) begin // RULE7
            dir_up_q <= 1'b1;
            cnt_q <= (cnt_q == cclr_q) ? mftcc_pkg::ZERO16 : cnt_q + mftcc_pkg::ONE16; // RULE6
         end else if (cclr_q == mftcc_pkg::ZERO16) begin
            cnt_q <= mftcc_pkg::ZERO16;
         end else if (dir_up_q) begin
            if (cnt_q == cclr_q) begin
               dir_up_q <= 1'b0;
               cnt_q <= cnt_q - mftcc_pkg::ONE16;
            end else begin
               cnt_q <= cnt_q + mftcc_pkg::ONE16;
            end
         end else if (cnt_q == mftcc_pkg::ZERO16) begin
            dir_up_q <= 1'b1;
            cnt_q <= mftcc_pkg::ONE16;
         end else begin
            cnt_q <= cnt_q - mftcc_pkg::ONE16;
         end
      end
   end

   // Compare-clear value and its buffer
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cclr_q <= mftcc_pkg::CCLR_RESET;
         cclr_buf_q <= mftcc_pkg::CCLR_RESET;
      end else begin
         if (wr_cclr) begin
            cclr_buf_q <= i_wdata;
         end
         if (wr_cclr && (!ctrl_q[mftcc_pkg::CTRL_BUFEN] || !running)) begin
            cclr_q <= i_wdata; // RULE4
         end else if (ctrl_q[mftcc_pkg::CTRL_BUFEN] && zero_ev) begin
            cclr_q <= cclr_buf_q; // RULE5
         end
      end
   end

   // Timer and generator flags; write one clears, set wins
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stat_q <= 4'h0;
      end else begin
         stat_q <= (stat_q & ~((i_wr && i_addr == mftcc_pkg::ADDR_STAT) ? i_wdata[3:0] : 4'h0))
                   | {gate_uflow, es_ev, zero_ev, cclr_ev}; // RULE2 RULE3 RULE21
      end
   end

   // Compare registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < mftcc_pkg::N_OC; i++) begin
            ocr_q[i] <= mftcc_pkg::ZERO16;
         end
      end else begin
         for (int i = 0; i < mftcc_pkg::N_OC; i++) begin
            if (i_wr && i_addr == mftcc_pkg::ADDR_OCR0 + 5'(i)) begin
               ocr_q[i] <= i_wdata;
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < mftcc_pkg::N_OC; i++) begin
         match[i] = tick && (cnt_q == ocr_q[i]); // RULE8 RULE9
      end
      for (int p = 0; p < mftcc_pkg::N_PAIR; p++) begin
         toggle[2*p] = match[2*p] || (oc_pair_q[p] && match[2*p+1]); // RULE10
         toggle[2*p+1] = match[2*p+1];
      end
   end

   // Compare outputs, pair mode and flags
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         oc_out_q <= 6'h00;
         oc_pair_q <= 3'h0;
      end else if (i_wr && i_addr == mftcc_pkg::ADDR_OC_CTRL) begin
         oc_out_q <= i_wdata[mftcc_pkg::OC_LEVEL_LSB +: 6]; // RULE11
         oc_pair_q <= i_wdata[mftcc_pkg::OC_PAIR_LSB +: 3];
      end else begin
         oc_out_q <= oc_out_q ^ toggle; // RULE9
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         oc_flag_q <= 6'h00;
      end else begin
         oc_flag_q <= (oc_flag_q & ~((i_wr && i_addr == mftcc_pkg::ADDR_OC_FLAG) ?
                      i_wdata[5:0] : 6'h00)) | match; // RULE9
      end
   end

   // Pin synchronisers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cap_s1_q <= 4'h0;
         cap_s2_q <= 4'h0;
         es_s1_q <= 1'b0;
         es_s2_q <= 1'b0;
         es_prev_q <= 1'b0;
      end else begin
         cap_s1_q <= i_capture_pin;
         cap_s2_q <= cap_s1_q;
         es_s1_q <= i_emergency_stop_input;
         es_s2_q <= es_s1_q;
         es_prev_q <= es_s2_q;
      end
   end

   // Capture edge detect on the counter tick
   always_comb begin
      for (int c = 0; c < mftcc_pkg::N_IC; c++) begin
         cap_ev[c] = tick && (((cap_s2_q[c] && !cap_prev_q[c]) && ic_sel_q[2*c]) ||
                     ((!cap_s2_q[c] && cap_prev_q[c]) && ic_sel_q[2*c+1])); // RULE13 RULE14
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cap_prev_q <= 4'h0;
      end else if (tick) begin
         cap_prev_q <= cap_s2_q; // RULE14
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ic_sel_q <= 8'h00;
      end else if (i_wr && i_addr == mftcc_pkg::ADDR_IC_CTRL) begin
         ic_sel_q <= i_wdata[7:0]; // RULE13
      end
   end

   // Capture registers, flags and edge direction, each channel alone
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ic_flag_q <= 4'h0;
         ic_rise_q <= 4'h0;
         for (int c = 0; c < mftcc_pkg::N_IC; c++) begin
            icr_q[c] <= mftcc_pkg::ZERO16;
         end
      end else begin
         ic_flag_q <= (ic_flag_q & ~((i_wr && i_addr == mftcc_pkg::ADDR_IC_FLAG) ?
                      i_wdata[3:0] : 4'h0)) | cap_ev; // RULE12
         for (int c = 0; c < mftcc_pkg::N_IC; c++) begin
            if (cap_ev[c]) begin
               icr_q[c] <= cnt_q; // RULE12 RULE15
               ic_rise_q[c] <= cap_s2_q[c]; // RULE13
            end
         end
      end
   end

   // Waveform generator setup
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wg_ctrl_q <= 3'h0;
         dead_q <= mftcc_pkg::ZERO16;
         gate_rel_q <= mftcc_pkg::ZERO16;
      end else if (i_wr) begin
         if (i_addr == mftcc_pkg::ADDR_WG_CTRL) begin
            wg_ctrl_q <= i_wdata[2:0];
         end
         if (i_addr == mftcc_pkg::ADDR_DEAD) begin
            dead_q <= i_wdata;
         end
         if (i_addr == mftcc_pkg::ADDR_GATE) begin
            gate_rel_q <= i_wdata;
         end
      end
   end

   // Gate timer started by the realtime compare on channel 0
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gate_cnt_q <= mftcc_pkg::ZERO16;
         gate_q <= 1'b0;
      end else begin
         if (wg_ctrl_q[mftcc_pkg::WG_GATE_EN] && match[0]) begin
            gate_cnt_q <= gate_rel_q; // RULE19
         end else if (gate_cnt_q != mftcc_pkg::ZERO16) begin
            gate_cnt_q <= gate_cnt_q - mftcc_pkg::ONE16;
         end
         gate_q <= (gate_cnt_q != mftcc_pkg::ZERO16) && !es_s2_q; // RULE18 RULE19 RULE20
      end
   end

   // Dead time per non-overlapping pair
   genvar gp;
   generate
      for (gp = 0; gp < mftcc_pkg::N_PAIR; gp++) begin : g_pair
         logic up_src;
         logic lo_src;
         logic up_prev_q;
         logic lo_prev_q;
         logic rise;
         logic [15:0] dt_q;
         // Two-channel mode takes the lower arm from the odd compare
         assign up_src = oc_out_q[2*gp]; // RULE22
         assign lo_src = wg_ctrl_q[mftcc_pkg::WG_TWO_CH] ? oc_out_q[2*gp+1] : !oc_out_q[2*gp];
         // Arms held off in the very cycle a source rises, before the timer loads
         assign rise = wg_ctrl_q[mftcc_pkg::WG_DT_EN] &&
            ((up_src && !up_prev_q) || (lo_src && !lo_prev_q));
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               up_prev_q <= 1'b0;
               lo_prev_q <= 1'b0;
               dt_q <= mftcc_pkg::ZERO16;
            end else begin
               up_prev_q <= up_src;
               lo_prev_q <= lo_src;
               if (rise) begin
                  dt_q <= dead_q; // RULE16 RULE17
               end else if (dt_q != mftcc_pkg::ZERO16) begin
                  dt_q <= dt_q - mftcc_pkg::ONE16;
               end
            end
         end
         always_comb begin
            rto_d[2*gp] = 1'b0;
            rto_d[2*gp+1] = 1'b0;
            if (!stat_q[mftcc_pkg::STAT_ESTOP] && !es_s2_q && !rise &&
                dt_q == mftcc_pkg::ZERO16) begin // RULE20
               rto_d[2*gp] = up_src && !lo_src; // RULE25
               rto_d[2*gp+1] = lo_src && !up_src; // RULE25
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rto_q <= 6'h00;
         adc_q <= 1'b0;
      end else begin
         rto_q <= rto_d; // RULE16
         adc_q <= zero_ev; // RULE23
      end
   end

   // Register read, data one cycle after the strobe
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_q <= mftcc_pkg::ZERO16;
      end else if (i_rd) begin
         rdata_q <= mftcc_pkg::ZERO16;
         case (i_addr)
            mftcc_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
            mftcc_pkg::ADDR_STAT: rdata_q <= {12'h000, stat_q};
            mftcc_pkg::ADDR_CCLR: rdata_q <= cclr_q;
            mftcc_pkg::ADDR_COUNT: rdata_q <= cnt_q;
            mftcc_pkg::ADDR_OC_CTRL: rdata_q <= {7'h00, oc_pair_q, oc_out_q};
            mftcc_pkg::ADDR_OC_FLAG: rdata_q <= {10'h000, oc_flag_q};
            mftcc_pkg::ADDR_IC_CTRL: rdata_q <= {8'h00, ic_sel_q};
            mftcc_pkg::ADDR_IC_FLAG: rdata_q <= {8'h00, ic_rise_q, ic_flag_q};
            mftcc_pkg::ADDR_WG_CTRL: rdata_q <= {13'h0000, wg_ctrl_q};
            mftcc_pkg::ADDR_DEAD: rdata_q <= dead_q;
            mftcc_pkg::ADDR_GATE: rdata_q <= gate_rel_q;
            default: begin
               if (i_addr >= mftcc_pkg::ADDR_OCR0 && i_addr < mftcc_pkg::ADDR_OC_CTRL) begin
                  rdata_q <= ocr_q[3'(i_addr - mftcc_pkg::ADDR_OCR0)];
               end else if (i_addr >= mftcc_pkg::ADDR_ICR0 &&
                            i_addr < mftcc_pkg::ADDR_IC_CTRL) begin
                  rdata_q <= icr_q[2'(i_addr - mftcc_pkg::ADDR_ICR0)];
               end
            end
         endcase
      end else begin
         rdata_q <= mftcc_pkg::ZERO16;
      end
   end

   assign o_rdata = rdata_q;
   assign o_realtime_out_u_upper = rto_q[0];
   assign o_realtime_out_x_lower = rto_q[1];
   assign o_realtime_out_v_upper = rto_q[2];
   assign o_realtime_out_y_lower = rto_q[3];
   assign o_realtime_out_w_upper = rto_q[4];
   assign o_realtime_out_z_lower = rto_q[5];
   assign o_compare_out = oc_out_q;
   assign o_pulse_generator_gate = gate_q;
   assign o_adc_trigger = adc_q;
   assign o_irq_compare_clear = stat_q[mftcc_pkg::STAT_CCLR]; // RULE24
   assign o_irq_zero = stat_q[mftcc_pkg::STAT_ZERO]; // RULE24
   assign o_irq_compare = oc_flag_q;
   assign o_irq_capture = ic_flag_q;
   assign o_irq_wavegen = stat_q[mftcc_pkg::STAT_ESTOP] | stat_q[mftcc_pkg::STAT_UFLOW]; // RULE21
endmodule : mftcc_top
`default_nettype wire

// file: dv/mftcc_chk.sv
// Port checker for the multifunction timer.
// Sees only top-level ports; bound below.
`timescale 1ns/1ns
`default_nettype none
module mftcc_chk (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [4:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic i_emergency_stop_input,
   input wire logic o_realtime_out_u_upper,
   input wire logic o_realtime_out_x_lower,
   input wire logic o_realtime_out_v_upper,
   input wire logic o_realtime_out_y_lower,
   input wire logic o_realtime_out_w_upper,
   input wire logic o_realtime_out_z_lower,
   input wire logic [5:0] o_compare_out,
   input wire logic o_pulse_generator_gate,
   input wire logic o_adc_trigger,
   input wire logic o_irq_zero,
   input wire logic [5:0] o_irq_compare,
   input wire logic [3:0] o_irq_capture,
   input wire logic o_irq_wavegen
);
   wire logic [5:0] arm = {o_realtime_out_z_lower, o_realtime_out_w_upper,
      o_realtime_out_y_lower, o_realtime_out_v_upper,
      o_realtime_out_x_lower, o_realtime_out_u_upper};
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_pair_excl: assert property (!(arm[0] && arm[1]) && !(arm[2] && arm[3])
      && !(arm[4] && arm[5])) else $error("Arms overlap");
   a_estop_off: assert property (i_emergency_stop_input [*5]
      |-> arm == 6'h00 && !o_pulse_generator_gate) else $error("Live in stop");
   a_estop_irq: assert property ($rose(i_emergency_stop_input) ##1
      i_emergency_stop_input [*4] |-> o_irq_wavegen) else $error("No stop request");
   a_trig_zero: assert property (o_adc_trigger |-> ##[0:1] o_irq_zero)
      else $error("Trigger no zero");
   a_trig_pulse: assert property (o_adc_trigger |=> !o_adc_trigger)
      else $error("Long trigger");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("Stray read data");
   a_cmp_sticky: assert property (|($past(o_irq_compare) & ~o_irq_compare)
      |-> $past(i_wr) && $past(i_addr) == mftcc_pkg::ADDR_OC_FLAG)
      else $error("Compare flag lost");
   a_cap_sticky: assert property (|($past(o_irq_capture) & ~o_irq_capture)
      |-> $past(i_wr) && $past(i_addr) == mftcc_pkg::ADDR_IC_FLAG)
      else $error("Capture flag lost");
   a_out_cause: assert property ($changed(o_compare_out) |-> (|o_irq_compare)
      || ($past(i_wr) && $past(i_addr) == mftcc_pkg::ADDR_OC_CTRL))
      else $error("Output moved");
   a_gate_cause: assert property ($rose(o_pulse_generator_gate) |-> o_irq_compare[0])
      else $error("Gate without match");
endmodule : mftcc_chk
bind mftcc_top mftcc_chk i_chk (.*);
`default_nettype wire

// file: dv/mftcc_far.sv
// Far side: capture sources and inverter gate drivers.
// Driver samples arms at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module mftcc_far (
   input wire logic i_clk,
   input wire logic [3:0] i_lvl,
   input wire logic [5:0] i_arm,
   output wire logic [3:0] o_pin,
   output wire logic o_shoot
);
   logic shoot_q = 1'b0;
   assign #7 o_pin = i_lvl;
   assign o_shoot = shoot_q;
   // Driver latches any shoot-through
   always @(negedge i_clk) begin
      if ((i_arm[0] && i_arm[1]) || (i_arm[2] && i_arm[3]) || (i_arm[4] && i_arm[5])) begin
         shoot_q <= 1'b1;
      end
   end
endmodule : mftcc_far
`default_nettype wire

// file: dv/mftcc_tb.sv
// Self-checking bench for the multifunction timer at 20 MHz.
// Drives registers, capture pins and stop; far side in mftcc_far.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %0t: %h, want %h", $time, (g), (e)); end end
module multifunction_timer_capture_compare_tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic estop = 1'b0;
   logic [3:0] lvl = 4'h2;
   wire logic [3:0] pin;
   wire logic [15:0] rdata;
   wire logic u, x, v, y, w, z, gate, trig, shoot, irq_cc, irq_z, irq_wg;
   wire logic [5:0] cmp_out, irq_cmp;
   wire logic [3:0] irq_cap;
   logic [15:0] a, b, c, d;
   int n;
   int n_fail = 0;
   int num_checks = 0;
   always #25 clk = ~clk;
   mftcc_top i_dut (.i_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_capture_pin(pin),
      .i_emergency_stop_input(estop), .o_realtime_out_u_upper(u),
      .o_realtime_out_x_lower(x), .o_realtime_out_v_upper(v), .o_realtime_out_y_lower(y),
      .o_realtime_out_w_upper(w), .o_realtime_out_z_lower(z), .o_compare_out(cmp_out),
      .o_pulse_generator_gate(gate), .o_adc_trigger(trig), .o_irq_compare_clear(irq_cc),
      .o_irq_zero(irq_z), .o_irq_compare(irq_cmp), .o_irq_capture(irq_cap),
      .o_irq_wavegen(irq_wg));
   mftcc_far i_far (.i_clk(clk), .i_lvl(lvl), .i_arm({z, w, y, v, x, u}), .o_pin(pin),
      .o_shoot(shoot));
   task automatic wr(input logic [4:0] ad, input logic [15:0] dt);
      @(posedge clk);
      addr <= ad;
      wdata <= dt;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [4:0] ad, output logic [15:0] q);
      @(posedge clk);
      addr <= ad;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      q = rdata;
   endtask : rd
   task automatic end_sim;
      $display("Checks %0d, errors %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic t_reset;
      rd(mftcc_pkg::ADDR_CTRL, d);
      `CHK(d, mftcc_pkg::CTRL_RESET)
      rd(mftcc_pkg::ADDR_CCLR, d);
      `CHK(d, mftcc_pkg::CCLR_RESET)
      rd(mftcc_pkg::ADDR_COUNT, d);
      `CHK(d, 16'h0000)
      rd(5'h1F, d);
      `CHK(d, 16'h0000)
   endtask : t_reset
   task automatic t_rate;
      for (int s = 0; s < 8; s++) begin
         wr(mftcc_pkg::ADDR_CTRL, 16'(s << 4));
         rd(mftcc_pkg::ADDR_COUNT, a);
         repeat ((8 << s) - 2) @(posedge clk);
         rd(mftcc_pkg::ADDR_COUNT, b);
         `CHK(b - a, 16'h0008)
      end
   endtask : t_rate
   task automatic t_wrap;
      wr(mftcc_pkg::ADDR_CTRL, 16'h0005);
      wr(mftcc_pkg::ADDR_CCLR, 16'h0003);
      wr(mftcc_pkg::ADDR_STAT, 16'h000F);
      wr(mftcc_pkg::ADDR_CTRL, 16'h0000);
      repeat (4) @(posedge clk);
      n = 0;
      repeat (16) begin
         @(posedge clk);
         #1;
         n += int'(trig);
      end
      `CHK(n, 4)
      rd(mftcc_pkg::ADDR_STAT, d);
      `CHK(d & 16'h0003, 16'h0003)
      `CHK({irq_cc, irq_z}, 2'b11)
      wr(mftcc_pkg::ADDR_CTRL, 16'h0012);
      rd(mftcc_pkg::ADDR_COUNT, a);
      repeat (10) begin
         rd(mftcc_pkg::ADDR_COUNT, b);
         `CHK((b - a == 16'h0001) || (a - b == 16'h0001), 1'b1)
         a = b;
      end
   endtask : t_wrap
   task automatic t_buffer;
      wr(mftcc_pkg::ADDR_CTRL, 16'h0009);
      wr(mftcc_pkg::ADDR_CCLR, 16'h0040);
      rd(mftcc_pkg::ADDR_CCLR, d);
      `CHK(d, 16'h0040)
      wr(mftcc_pkg::ADDR_CTRL, 16'h000D);
      wr(mftcc_pkg::ADDR_CTRL, 16'h0008);
      repeat (5) @(posedge clk);
      wr(mftcc_pkg::ADDR_CCLR, 16'h0030);
      rd(mftcc_pkg::ADDR_CCLR, d);
      `CHK(d, 16'h0040)
      repeat (70) @(posedge clk);
      rd(mftcc_pkg::ADDR_CCLR, d);
      `CHK(d, 16'h0030)
      wr(mftcc_pkg::ADDR_CTRL, 16'h0005);
   endtask : t_buffer
   task automatic t_compare;
      wr(mftcc_pkg::ADDR_CCLR, 16'h0010);
      for (int i = 0; i < 6; i++) wr(5'(mftcc_pkg::ADDR_OCR0 + i), 16'(2 + i));
      wr(mftcc_pkg::ADDR_OC_FLAG, 16'h003F);
      wr(mftcc_pkg::ADDR_OC_CTRL, 16'h0055);
      `CHK(cmp_out, 6'h15)
      wr(mftcc_pkg::ADDR_CTRL, 16'h0000);
      repeat (12) @(posedge clk);
      wr(mftcc_pkg::ADDR_CTRL, 16'h0001);
      `CHK(cmp_out, 6'h2B)
      `CHK(irq_cmp, 6'h3F)
      wr(mftcc_pkg::ADDR_OC_FLAG, 16'h003F);
      `CHK(irq_cmp, 6'h00)
   endtask : t_compare
   task automatic t_gate;
      wr(mftcc_pkg::ADDR_GATE, 16'h0005);
      wr(mftcc_pkg::ADDR_WG_CTRL, 16'h0004);
      wr(mftcc_pkg::ADDR_STAT, 16'h000F);
      wr(mftcc_pkg::ADDR_CTRL, 16'h0005);
      wr(mftcc_pkg::ADDR_CTRL, 16'h0000);
      n = 0;
      repeat (15) begin
         @(posedge clk);
         #1;
         n += int'(gate);
      end
      wr(mftcc_pkg::ADDR_CTRL, 16'h0001);
      `CHK(n, 5)
      rd(mftcc_pkg::ADDR_STAT, d);
      `CHK(d & 16'h0008, 16'h0008)
      wr(mftcc_pkg::ADDR_STAT, 16'h000F);
   endtask : t_gate
   task automatic t_dead;
      wr(mftcc_pkg::ADDR_DEAD, 16'h0004);
      wr(mftcc_pkg::ADDR_WG_CTRL, 16'h0001);
      wr(mftcc_pkg::ADDR_OC_CTRL, 16'h0000);
      repeat (10) @(posedge clk);
      #1;
      `CHK({u, x}, 2'b01)
      wr(mftcc_pkg::ADDR_OC_CTRL, 16'h0001);
      n = 0;
      for (int k = 0; k < 40 && u !== 1'b1; k++) begin
         @(posedge clk);
         #1;
         if (!u && !x) n++;
      end
      `CHK(n >= 4, 1'b1)
      `CHK(u, 1'b1)
   endtask : t_dead
   task automatic t_estop;
      @(posedge clk);
      estop <= 1'b1;
      repeat (7) @(posedge clk);
      #1;
      `CHK({u, x, v, y, w, z, gate}, 7'h00)
      `CHK(irq_wg, 1'b1)
      @(posedge clk);
      estop <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      `CHK(u, 1'b0)
      wr(mftcc_pkg::ADDR_STAT, 16'h0004);
      repeat (12) @(posedge clk);
      #1;
      `CHK({u, irq_wg}, 2'b10)
   endtask : t_estop
   task automatic t_capture;
      wr(mftcc_pkg::ADDR_CCLR, 16'hFFFF);
      wr(mftcc_pkg::ADDR_CTRL, 16'h0000);
      wr(mftcc_pkg::ADDR_IC_CTRL, 16'h0039);
      wr(mftcc_pkg::ADDR_IC_FLAG, 16'h000F);
      rd(mftcc_pkg::ADDR_COUNT, a);
      @(posedge clk);
      lvl <= 4'hD;
      repeat (8) @(posedge clk);
      rd(mftcc_pkg::ADDR_COUNT, b);
      `CHK(irq_cap, 4'h7)
      rd(mftcc_pkg::ADDR_IC_FLAG, d);
      `CHK(d[7:0], 8'h57)
      rd(mftcc_pkg::ADDR_ICR0, c);
      rd(5'(mftcc_pkg::ADDR_ICR0 + 2), d);
      `CHK(c, d)
      `CHK(c > a && c < b, 1'b1)
      wr(mftcc_pkg::ADDR_IC_FLAG, 16'h000F);
      @(posedge clk);
      lvl <= 4'h0;
      repeat (8) @(posedge clk);
      rd(mftcc_pkg::ADDR_IC_FLAG, d);
      `CHK(d[7:0], 8'h14)
   endtask : t_capture
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_rate();
      t_wrap();
      t_buffer();
      t_compare();
      t_gate();
      t_dead();
      t_estop();
      t_capture();
      `CHK(shoot, 1'b0)
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_sim();
   end
endmodule : multifunction_timer_capture_compare_tb
`default_nettype wire
